// ---- hdl/acde_pkg.sv ----
// Summary of operation
// R01: host loads task-file registers first, then writes the opcode to launch.
// R02: read-type DMA command enters prepare state and stages next data frame.
// R03: prepare state goes to data send once one frame is staged.
// R04: prepare goes to status send when all data sent or on abort.
// R05: data send requests one Data FIS of at most 2048 dwords.
// R06: after a Data FIS completes, return to prepare state.
// R07: status send requests Register D2H FIS with interrupt bit one.
// R08: after status FIS sent, enter device idle and accept next command.
// R09: decode power opcodes 98/E5, 96/E2, 94/E0, E6; standby uses count (the code ignores count for standby).
// R10: decode read family opcodes using count, sector, cylinder, drive/head.
// R11: decode write family opcodes using count, sector, cylinder, drive/head.
// R12: drive-only commands keep drive select only; others keep drive and head.
// R13: power query reports mode without changing it or the standby timer.
// R14: microcode length is LBA low high byte, sector count low byte.
// R15: microcode download 92h passes features value as its effect select.
// R16: flush E7h completes only after flush done or error.
// R17: flush with write cache disabled completes at once without error.
// R18: flush on wide-address device still flushes whole cache.
// R19: erase sector C0h pre-erases addressed sectors.
// R20: diagnostic 90h runs self-test and reports via status path.
// R21: integrated DMA moves data between host memory and flash.
// R22: idle 97/E3 sets idle mode; zero count disables auto power-down.
// R23: read sectors count zero means 256 sectors.
// R24: unsupported opcode aborts with error, no data transfer.
// R25: busy from opcode acceptance until status frame sent; new opcodes ignored.
package acde_pkg;
  localparam logic [7:0] OP_CHKPWR0 = 8'h98;
  localparam logic [7:0] OP_CHKPWR1 = 8'hE5;
  localparam logic [7:0] OP_STBY0 = 8'h96;
  localparam logic [7:0] OP_STBY1 = 8'hE2;
  localparam logic [7:0] OP_STBYI0 = 8'h94;
  localparam logic [7:0] OP_STBYI1 = 8'hE0;
  localparam logic [7:0] OP_SLEEP = 8'hE6;
  localparam logic [7:0] OP_IDLE0 = 8'h97;
  localparam logic [7:0] OP_IDLE1 = 8'hE3;
  localparam logic [7:0] OP_RD_SEC = 8'h20;
  localparam logic [7:0] OP_RD_SECX = 8'h24;
  localparam logic [7:0] OP_RD_DMA = 8'hC8;
  localparam logic [7:0] OP_RD_DMAX = 8'h25;
  localparam logic [7:0] OP_RD_Q = 8'hC7;
  localparam logic [7:0] OP_RD_QX = 8'h26;
  localparam logic [7:0] OP_RD_MUL = 8'hC4;
  localparam logic [7:0] OP_RD_MULX = 8'h29;
  localparam logic [7:0] OP_WR_SEC = 8'h30;
  localparam logic [7:0] OP_WR_SECX = 8'h34;
  localparam logic [7:0] OP_WR_DMA = 8'hCA;
  localparam logic [7:0] OP_WR_DMAX = 8'h35;
  localparam logic [7:0] OP_WR_FUAX = 8'h3D;
  localparam logic [7:0] OP_WR_Q = 8'hCC;
  localparam logic [7:0] OP_WR_QX = 8'h36;
  localparam logic [7:0] OP_WR_QFX = 8'h3E;
  localparam logic [7:0] OP_WR_MUL = 8'hC5;
  localparam logic [7:0] OP_WR_MULX = 8'h39;
  localparam logic [7:0] OP_WR_MULF = 8'hCE;
  localparam logic [7:0] OP_MICROCODE = 8'h92;
  localparam logic [7:0] OP_FLUSH = 8'hE7;
  localparam logic [7:0] OP_ERASE = 8'hC0;
  localparam logic [7:0] OP_DIAG = 8'h90;
  // apb map
  localparam logic [11:0] ADDR_FEAT = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_SECT = 12'h008;
  localparam logic [11:0] ADDR_CYL = 12'h00C;
  localparam logic [11:0] ADDR_DRVHD = 12'h010;
  localparam logic [11:0] ADDR_CMD = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_CFG = 12'h01C;
  localparam logic [11:0] ADDR_XFER = 12'h020;
  localparam logic [11:0] ADDR_PARAM = 12'h024;
  // field positions
  localparam int DRV_BIT = 4;
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int CFG_WCACHE = 0;
  localparam int CFG_WIDE = 1;
  // counts and reset values
  localparam logic [11:0] FIS_MAX_DW = 12'h800;
  localparam logic [16:0] SECT_256 = 17'h00100;
  localparam logic [1:0] PM_ACTIVE = 2'h3;
  localparam logic [1:0] PM_IDLE = 2'h2;
  localparam logic [1:0] PM_STBY = 2'h0;
  localparam logic [1:0] PM_SLEEP = 2'h1;
  localparam logic [7:0] CHKPWR_ACTIVE = 8'hFF;
  localparam logic [7:0] CHKPWR_STBY = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [6:0] DW_PER_SECT = 7'h7F;

  typedef enum {
    device_idle_state,
    exec_state,
    dma_in_prepare_state,
    data_send_state,
    status_send_state
  } acde_state_e;

  typedef enum {
    CL_NONE, CL_READ_DMA, CL_READ_PIO, CL_WRITE, CL_POWER, CL_CHKPWR,
    CL_IDLE, CL_MCODE, CL_FLUSH, CL_ERASE, CL_DIAG, CL_ABORT
  } acde_class_e;

  typedef struct packed {
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] sector;
    logic [15:0] cylinder;
    logic [7:0] drvhd;
  } acde_tf_s;

  // request to transport layer
  typedef struct packed {
    logic data_req;
    logic [11:0] data_dw;
    logic reg_req;
    logic irq_bit;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] count;
  } acde_fis_s;

  // request to flash side
  typedef struct packed {
    logic req;
    logic [7:0] opcode;
    logic [7:0] features;
    logic [27:0] lba;
    logic [16:0] sectors;
  } acde_media_s;
endpackage : acde_pkg

// ---- hdl/acde_engine.sv ----
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module acde_engine (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transport layer
  output acde_pkg::acde_fis_s fis_o,
  input wire logic fis_done,
  input wire logic fis_err,
  // flash and dma side
  output acde_pkg::acde_media_s media_o,
  input wire logic stage_ready,
  input wire logic media_done,
  input wire logic media_err,
  // status
  output logic busy
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    acde_pkg::acde_state_e st;
    acde_pkg::acde_class_e cls;
    acde_pkg::acde_tf_s tf;
    logic [7:0] opcode;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] ret_count;
    logic [1:0] pmode;
    logic auto_pd;
    logic [1:0] cfg;
    logic [16:0] remain;
    logic [16:0] xfer_len;
    acde_pkg::acde_fis_s fis;
    acde_pkg::acde_media_s media;
    logic [31:0] rdata;
  } acde_state_s;

  acde_state_s s_reg;
  acde_state_s s_next;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  acde_pkg::acde_class_e dec;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  // ****************************************************
  // opcode decode
  // ****************************************************
  always_comb
  begin
    case (pwdata[7:0])
      acde_pkg::OP_CHKPWR0, acde_pkg::OP_CHKPWR1:
        dec = acde_pkg::CL_CHKPWR; // [R09]
      acde_pkg::OP_STBY0, acde_pkg::OP_STBY1, acde_pkg::OP_STBYI0,
      acde_pkg::OP_STBYI1, acde_pkg::OP_SLEEP:
        dec = acde_pkg::CL_POWER; // [R09]
      acde_pkg::OP_IDLE0, acde_pkg::OP_IDLE1:
        dec = acde_pkg::CL_IDLE; // [R22]
      acde_pkg::OP_RD_DMA, acde_pkg::OP_RD_DMAX, acde_pkg::OP_RD_Q,
      acde_pkg::OP_RD_QX:
        dec = acde_pkg::CL_READ_DMA; // [R10]
      acde_pkg::OP_RD_SEC, acde_pkg::OP_RD_SECX, acde_pkg::OP_RD_MUL,
      acde_pkg::OP_RD_MULX:
        dec = acde_pkg::CL_READ_PIO; // [R10]
      acde_pkg::OP_WR_SEC, acde_pkg::OP_WR_SECX, acde_pkg::OP_WR_DMA,
      acde_pkg::OP_WR_DMAX, acde_pkg::OP_WR_FUAX, acde_pkg::OP_WR_Q,
      acde_pkg::OP_WR_QX, acde_pkg::OP_WR_QFX, acde_pkg::OP_WR_MUL,
      acde_pkg::OP_WR_MULX, acde_pkg::OP_WR_MULF:
        dec = acde_pkg::CL_WRITE; // [R11]
      acde_pkg::OP_MICROCODE: dec = acde_pkg::CL_MCODE;
      acde_pkg::OP_FLUSH: dec = acde_pkg::CL_FLUSH;
      acde_pkg::OP_ERASE: dec = acde_pkg::CL_ERASE;
      acde_pkg::OP_DIAG: dec = acde_pkg::CL_DIAG;
      default: dec = acde_pkg::CL_ABORT; // [R24]
    endcase
  end

  assign mapped = (paddr <= acde_pkg::ADDR_PARAM) && (paddr[1:0] == 2'h0);

  // ****************************************************
  // next state
  // ****************************************************
  always_comb
  begin
    logic [16:0] cnt;
    logic [16:0] chunk;
    logic drv_only;
    s_next = s_reg;
    cnt = {9'h000, s_reg.tf.count};
    chunk = 17'h00000;
    drv_only = 1'b0;
    s_next.fis.data_req = 1'b0;
    s_next.fis.reg_req = 1'b0;
    s_next.media.req = 1'b0;
    // register writes; task file locked while busy
    if (wr_acc && !s_reg.status[acde_pkg::ST_BSY])
    begin
      case (paddr)
        acde_pkg::ADDR_FEAT: s_next.tf.features = pwdata[7:0];
        acde_pkg::ADDR_COUNT: s_next.tf.count = pwdata[7:0];
        acde_pkg::ADDR_SECT: s_next.tf.sector = pwdata[7:0];
        acde_pkg::ADDR_CYL: s_next.tf.cylinder = pwdata[15:0];
        acde_pkg::ADDR_DRVHD: s_next.tf.drvhd = pwdata[7:0];
        acde_pkg::ADDR_CFG: s_next.cfg = pwdata[1:0];
        default: s_next.cfg = s_reg.cfg;
      endcase
    end
    // read mux
    case (paddr)
      acde_pkg::ADDR_FEAT: s_next.rdata = {24'h0, s_reg.tf.features};
      acde_pkg::ADDR_COUNT: s_next.rdata = {24'h0, s_reg.ret_count};
      acde_pkg::ADDR_SECT: s_next.rdata = {24'h0, s_reg.tf.sector};
      acde_pkg::ADDR_CYL: s_next.rdata = {16'h0, s_reg.tf.cylinder};
      acde_pkg::ADDR_DRVHD: s_next.rdata = {24'h0, s_reg.tf.drvhd};
      acde_pkg::ADDR_CMD: s_next.rdata = {24'h0, s_reg.opcode};
      acde_pkg::ADDR_STATUS:
        s_next.rdata = {16'h0, s_reg.error, s_reg.status};
      acde_pkg::ADDR_CFG:
        s_next.rdata = {27'h0, s_reg.auto_pd, s_reg.pmode, s_reg.cfg};
      acde_pkg::ADDR_XFER: s_next.rdata = {15'h0, s_reg.remain};
      acde_pkg::ADDR_PARAM: s_next.rdata = {15'h0, s_reg.xfer_len};
      default: s_next.rdata = 32'h0000_0000;
    endcase
    case (s_reg.st)
      acde_pkg::device_idle_state:
      begin
        // opcode write launches after task file is loaded
        if (wr_acc && paddr == acde_pkg::ADDR_CMD) // [R01]
        begin
          s_next.opcode = pwdata[7:0];
          s_next.cls = dec;
          s_next.status = 8'h80; // [R25]
          s_next.error = 8'h00;
          s_next.ret_count = s_reg.tf.count;
          drv_only = (dec != acde_pkg::CL_READ_DMA) &&
            (dec != acde_pkg::CL_READ_PIO) &&
            (dec != acde_pkg::CL_WRITE);
          if (drv_only)
            s_next.tf.drvhd = s_reg.tf.drvhd & 8'h10; // [R12]
          s_next.media.opcode = pwdata[7:0];
          s_next.media.features = s_reg.tf.features; // [R15]
          // head bits mean nothing to a drive-only command
          s_next.media.lba = {drv_only ? 4'h0 : s_reg.tf.drvhd[3:0],
            s_reg.tf.cylinder, s_reg.tf.sector}; // [R12]
          if (dec == acde_pkg::CL_MCODE)
            cnt = {1'b0, s_reg.tf.sector, s_reg.tf.count}; // [R14]
          else if (s_reg.tf.count == 8'h00)
            cnt = acde_pkg::SECT_256; // [R23]
          s_next.xfer_len = cnt;
          s_next.remain = cnt;
          s_next.media.sectors = cnt;
          s_next.st = (dec == acde_pkg::CL_READ_DMA) ?
            acde_pkg::dma_in_prepare_state : acde_pkg::exec_state; // [R02]
          if (dec == acde_pkg::CL_READ_DMA || dec == acde_pkg::CL_WRITE ||
              dec == acde_pkg::CL_READ_PIO || dec == acde_pkg::CL_ERASE ||
              dec == acde_pkg::CL_DIAG ||
              (dec == acde_pkg::CL_MCODE && cnt != 17'h0) ||
              (dec == acde_pkg::CL_FLUSH &&
               s_reg.cfg[acde_pkg::CFG_WCACHE]))
            s_next.media.req = 1'b1; // [R16] [R18] [R19] [R20] [R21]
        end
      end
      acde_pkg::exec_state:
      begin
        case (s_reg.cls)
          acde_pkg::CL_CHKPWR:
          begin
            s_next.ret_count = (s_reg.pmode == acde_pkg::PM_STBY) ?
              acde_pkg::CHKPWR_STBY : acde_pkg::CHKPWR_ACTIVE; // [R13]
            s_next.st = acde_pkg::status_send_state;
          end
          acde_pkg::CL_POWER:
          begin
            s_next.pmode = (s_reg.opcode == acde_pkg::OP_SLEEP) ?
              acde_pkg::PM_SLEEP : acde_pkg::PM_STBY; // [R09]
            s_next.st = acde_pkg::status_send_state;
          end
          acde_pkg::CL_IDLE:
          begin
            s_next.pmode = acde_pkg::PM_IDLE; // [R22]
            s_next.auto_pd = (s_reg.tf.count != 8'h00);
            s_next.st = acde_pkg::status_send_state;
          end
          acde_pkg::CL_ABORT:
          begin
            s_next.error[acde_pkg::ER_ABRT] = 1'b1; // [R24]
            s_next.st = acde_pkg::status_send_state;
          end
          acde_pkg::CL_FLUSH, acde_pkg::CL_MCODE:
          begin
            // nothing to move: finish at once without error
            if (!s_reg.cfg[acde_pkg::CFG_WCACHE] &&
                s_reg.cls == acde_pkg::CL_FLUSH)
              s_next.st = acde_pkg::status_send_state; // [R17]
            else if (s_reg.cls == acde_pkg::CL_MCODE &&
                s_reg.xfer_len == 17'h0)
              s_next.st = acde_pkg::status_send_state; // [R14]
            else if (media_done || media_err)
            begin
              s_next.error[acde_pkg::ER_ABRT] = media_err;
              s_next.st = acde_pkg::status_send_state; // [R16]
            end
          end
          default:
          begin
            if (media_done || media_err)
            begin
              s_next.error[acde_pkg::ER_ABRT] = media_err; // [R20]
              s_next.st = acde_pkg::status_send_state;
            end
          end
        endcase
      end
      acde_pkg::dma_in_prepare_state:
      begin
        if (s_reg.remain == 17'h0 || media_err)
        begin
          s_next.error[acde_pkg::ER_ABRT] = media_err;
          s_next.st = acde_pkg::status_send_state; // [R04]
        end
        else if (stage_ready)
        begin
          // 16 sectors of 128 dwords fill the largest frame
          chunk = (s_reg.remain > 17'h00010) ? 17'h00010 : s_reg.remain;
          s_next.remain = s_reg.remain - chunk;
          s_next.fis.data_dw = chunk[4:0] == 5'h10 ?
            acde_pkg::FIS_MAX_DW : {chunk[4:0], 7'h00}; // [R05]
          s_next.fis.data_req = 1'b1;
          s_next.st = acde_pkg::data_send_state; // [R03]
        end
      end
      acde_pkg::data_send_state:
      begin
        if (fis_done || fis_err)
        begin
          if (fis_err)
            s_next.remain = 17'h0;
          s_next.error[acde_pkg::ER_ABRT] = fis_err;
          s_next.st = acde_pkg::dma_in_prepare_state; // [R06]
        end
      end
      acde_pkg::status_send_state:
      begin
        if (!s_reg.fis.reg_req && !s_reg.status[acde_pkg::ST_DRDY])
        begin
          s_next.status = {1'b0, 1'b1, 5'h00, s_reg.error != 8'h00};
          s_next.fis.status = {1'b0, 1'b1, 5'h00, s_reg.error != 8'h00};
          s_next.fis.error = s_reg.error;
          s_next.fis.count = s_reg.ret_count;
          s_next.fis.irq_bit = 1'b1; // [R07]
          s_next.fis.reg_req = 1'b1;
          s_next.status[acde_pkg::ST_BSY] = 1'b1;
        end
        if (fis_done)
        begin
          s_next.status[acde_pkg::ST_BSY] = 1'b0; // [R25]
          s_next.st = acde_pkg::device_idle_state; // [R08]
        end
      end
      default: s_next.st = acde_pkg::device_idle_state;
    endcase
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.st <= acde_pkg::device_idle_state;
      s_reg.cls <= acde_pkg::CL_NONE;
      s_reg.status <= acde_pkg::STATUS_RST;
      s_reg.pmode <= acde_pkg::PM_ACTIVE;
    end
    else
      s_reg <= s_next;
  end

  assign prdata = s_reg.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign fis_o = s_reg.fis;
  assign media_o = s_reg.media;
  assign busy = s_reg.status[acde_pkg::ST_BSY];

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  frame_size_a: assert property (fis_o.data_req |-> // [R05]
    fis_o.data_dw <= acde_pkg::FIS_MAX_DW && fis_o.data_dw != 12'h0)
    else $error("data frame size out of range");
  prep_to_send_a: assert property ( // [R03]
    s_reg.st == acde_pkg::dma_in_prepare_state && stage_ready &&
    s_reg.remain != 17'h0 && !media_err |=>
    s_reg.st == acde_pkg::data_send_state && fis_o.data_req)
    else $error("staged data did not start a frame");
  send_return_a: assert property ( // [R06]
    s_reg.st == acde_pkg::data_send_state && fis_done |=>
    s_reg.st == acde_pkg::dma_in_prepare_state)
    else $error("no return to prepare after frame");
  done_status_a: assert property ( // [R04]
    s_reg.st == acde_pkg::dma_in_prepare_state && s_reg.remain == 17'h0 |=>
    s_reg.st == acde_pkg::status_send_state)
    else $error("finished read did not send status");
  status_irq_a: assert property (fis_o.reg_req |-> fis_o.irq_bit) // [R07]
    else $error("status frame without interrupt bit");
  idle_after_a: assert property ( // [R08]
    s_reg.st == acde_pkg::status_send_state && fis_done |=>
    s_reg.st == acde_pkg::device_idle_state && !busy)
    else $error("not idle after status frame");
  busy_hold_a: assert property ( // [R25]
    s_reg.st != acde_pkg::device_idle_state && !$past(fis_done) |-> busy)
    else $error("busy dropped during command");
  abort_nodata_a: assert property ( // [R24]
    s_reg.cls == acde_pkg::CL_ABORT && s_reg.st == acde_pkg::exec_state |=>
    s_reg.error[acde_pkg::ER_ABRT] && !fis_o.data_req)
    else $error("unsupported opcode not aborted");
  chkpwr_keep_a: assert property ( // [R13]
    s_reg.cls == acde_pkg::CL_CHKPWR && s_reg.st == acde_pkg::exec_state |=>
    $stable(s_reg.pmode) && $stable(s_reg.auto_pd))
    else $error("power query changed power state");
  read_start_a: assert property ( // [R02]
    s_reg.st == acde_pkg::device_idle_state && wr_acc &&
    paddr == acde_pkg::ADDR_CMD && dec == acde_pkg::CL_READ_DMA |=>
    s_reg.st == acde_pkg::dma_in_prepare_state)
    else $error("read dma did not enter prepare");
  drive_mask_a: assert property ( // [R12]
    s_reg.st == acde_pkg::device_idle_state && wr_acc &&
    paddr == acde_pkg::ADDR_CMD &&
    (dec == acde_pkg::CL_ERASE || dec == acde_pkg::CL_DIAG) |=>
    (s_reg.tf.drvhd & 8'hEF) == 8'h00 && s_reg.media.lba[27:24] == 4'h0)
    else $error("drive-only command kept head bits");
  flush_quick_a: assert property ( // [R17]
    s_reg.st == acde_pkg::exec_state && s_reg.cls == acde_pkg::CL_FLUSH &&
    !s_reg.cfg[acde_pkg::CFG_WCACHE] |=>
    s_reg.st == acde_pkg::status_send_state && s_reg.error == 8'h00)
    else $error("uncached flush did not end at once");
  zero_count_a: assert property ( // [R23]
    s_reg.st == acde_pkg::device_idle_state && wr_acc &&
    paddr == acde_pkg::ADDR_CMD && s_reg.tf.count == 8'h00 &&
    (dec == acde_pkg::CL_READ_PIO || dec == acde_pkg::CL_READ_DMA) |=>
    s_reg.xfer_len == acde_pkg::SECT_256)
    else $error("zero count did not mean 256 sectors");
  mcode_len_a: assert property ( // [R14]
    s_reg.st == acde_pkg::device_idle_state && wr_acc &&
    paddr == acde_pkg::ADDR_CMD && dec == acde_pkg::CL_MCODE |=>
    s_reg.xfer_len[15:8] == s_reg.tf.sector &&
    s_reg.xfer_len[7:0] == s_reg.tf.count)
    else $error("microcode length built wrongly");
  idle_mode_a: assert property ( // [R22]
    s_reg.st == acde_pkg::exec_state && s_reg.cls == acde_pkg::CL_IDLE |=>
    s_reg.pmode == acde_pkg::PM_IDLE &&
    s_reg.auto_pd == (s_reg.tf.count != 8'h00))
    else $error("idle command did not set idle mode");

  read_done_c: cover property (s_reg.st == acde_pkg::data_send_state ##[1:50]
    s_reg.st == acde_pkg::status_send_state);
  abort_c: cover property (s_reg.cls == acde_pkg::CL_ABORT && fis_o.reg_req);
  flush_c: cover property (s_reg.cls == acde_pkg::CL_FLUSH && fis_o.reg_req);
  mcode_c: cover property (s_reg.cls == acde_pkg::CL_MCODE && media_o.req);
endmodule : acde_engine

// ---- bench/acde_partner.sv ----
`timescale 1ns/1ns
module acde_partner (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the engine
  input acde_pkg::acde_fis_s fis_o,
  input acde_pkg::acde_media_s media_o,
  // answers to the engine
  output logic fis_done,
  output logic fis_err,
  output logic stage_ready,
  output logic media_done,
  output logic media_err,
  // scenario control
  input wire logic slow,
  input wire logic fail_media,
  input wire logic stage_on
);
  logic [3:0] fcnt;
  logic [3:0] mcnt;
  logic fbusy;
  logic mbusy;
  // ****************************************
  // transport and flash answers
  // ****************************************
  // frame failure needs a link model, so frames always succeed here
  assign fis_err = 1'b0;
  // nothing new is staged while a frame is still on the wire
  assign stage_ready = stage_on & ~fbusy;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {fcnt, mcnt, fbusy, mbusy} <= 10'h000;
      {fis_done, media_done, media_err} <= 3'h0;
    end
    else
    begin
      {fis_done, media_done, media_err} <= 3'h0;
      if (fis_o.data_req | fis_o.reg_req)
      begin
        fbusy <= 1'b1;
        fcnt <= slow ? 4'h9 : 4'h1;
      end
      else if (fbusy)
      begin
        fcnt <= fcnt - 4'h1;
        fbusy <= fcnt != 4'h1;
        fis_done <= fcnt == 4'h1;
      end
      if (media_o.req)
      begin
        mbusy <= 1'b1;
        mcnt <= slow ? 4'hC : 4'h2;
      end
      else if (mbusy)
      begin
        mcnt <= mcnt - 4'h1;
        mbusy <= mcnt != 4'h1;
        media_done <= mcnt == 4'h1 && !fail_media;
        media_err <= mcnt == 4'h1 && fail_media;
      end
    end
  end
endmodule : acde_partner

// ---- bench/tb_ata_command_dma_in_engine.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %0h %0h", $time, (g), (e)); end end
module tb_ata_command_dma_in_engine;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, slow = 1'b0, fail_media = 1'b0, stage_on = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h57FE12A3;
  logic pready, pslverr, busy, fis_done, fis_err, stage_ready, er;
  logic media_done, media_err, mpend = 1'b0, stg_d = 1'b0;
  logic [7:0] exp_dh;
  acde_pkg::acde_fis_s fis_o;
  acde_pkg::acde_media_s media_o;
  logic [63:0] exp_q[$];
  int checked = 0, mismatches = 0;
  // count, kind/abort/query nibble, expected count, opcode
  logic [27:0] cmds[$] = {
    28'h05_4_00_20, 28'h05_4_00_24, 28'h05_4_00_C4, 28'h05_4_00_29,
    28'h05_4_00_30, 28'h05_4_00_34, 28'h05_4_00_CA, 28'h05_4_00_35,
    28'h05_4_00_3D, 28'h05_4_00_CC, 28'h05_4_00_36, 28'h05_4_00_3E,
    28'h05_4_00_C5, 28'h05_4_00_39, 28'h05_4_00_CE, 28'h05_4_00_C0,
    28'h05_4_00_90, 28'h14_8_00_C8, 28'h10_8_00_25, 28'h00_8_00_C7,
    28'h01_8_00_26, 28'h05_2_00_50, 28'h05_2_00_EC, 28'h05_2_00_10,
    28'h05_0_00_E7, 28'h00_0_00_97, 28'h05_1_FF_98, 28'h05_1_FF_E5,
    28'h05_0_00_E2, 28'h05_1_00_E5, 28'h05_1_00_98, 28'h05_0_00_96,
    28'h05_0_00_E3, 28'h05_1_FF_98, 28'h05_0_00_94, 28'h05_0_00_E0,
    28'h05_0_00_E6};
  always #10 pclk = ~pclk;
  acde_engine DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fis_o, .fis_done, .fis_err,
    .media_o, .stage_ready, .media_done, .media_err, .busy);
  acde_partner far_end (.pclk, .presetn, .fis_o, .media_o, .fis_done,
    .fis_err, .stage_ready, .media_done, .media_err, .slow, .fail_media,
    .stage_on);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // stimulus
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic start(input logic [7:0] op, cnt, input logic [1:0] kind,
    input logic ab, chk, input logic [7:0] ecnt);
    int n;
    int k;
    seed = lfsr(seed);
    n = cnt == 8'h00 ? 256 : int'(cnt);
    apb(1'b1, acde_pkg::ADDR_FEAT, {24'h0, seed[7:0]});
    apb(1'b1, acde_pkg::ADDR_COUNT, {24'h0, cnt});
    // microcode length takes lba low as its upper byte
    apb(1'b1, acde_pkg::ADDR_SECT,
      {24'h0, op == 8'h92 ? {cnt[3:0], cnt[7:4]} : seed[15:8]});
    apb(1'b1, acde_pkg::ADDR_CYL, {16'h0, seed[31:16]});
    apb(1'b1, acde_pkg::ADDR_DRVHD, {24'h0, seed[23:16]});
    exp_dh = seed[23:16] & ((kind == 2'h2 || (kind == 2'h1 &&
      op[7:4] != 4'h9 && op != 8'hC0 && op != 8'hE7)) ? 8'hFF : 8'h10);
    // dma reads start the media side too
    if (kind != 2'h0)
      exp_q.push_back({32'hFFFFFFFF, 8'h02, op, seed[7:0], 8'h00});
    while (kind == 2'h2 && n > 0)
    begin
      k = n > 16 ? 16 : n;
      exp_q.push_back({32'hFFFFFFFF, 8'h01, 4'h0, 12'(k * 128), 8'h00});
      n -= k;
    end
    exp_q.push_back({8'hFF, 8'hE0, chk ? 8'hFF : 8'h00, 8'hFF, 8'h03,
      1'b1, ab, ab, 5'h00, ecnt, 8'h00});
    apb(1'b1, acde_pkg::ADDR_CMD, {24'h0, op});
  endtask : start
  task automatic wait_done;
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    `CHK(busy, 1'b1)
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK(busy, 1'b0)
    `CHK(exp_q.size(), 0)
    apb(1'b0, acde_pkg::ADDR_DRVHD, 32'h0);
    `CHK(rd[7:0], exp_dh)
  endtask : wait_done
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, acde_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h00000040)
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, acde_pkg::ADDR_CFG, 32'h0);
    foreach (cmds[i])
    begin
      start(cmds[i][7:0], cmds[i][27:20], cmds[i][19:18], cmds[i][17],
        cmds[i][16], cmds[i][15:8]);
      wait_done();
    end
    apb(1'b0, acde_pkg::ADDR_CFG, 32'h0);
    `CHK(rd[3:2], acde_pkg::PM_SLEEP)
    // sleep is left here through reset; an idle or standby command would also leave it
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, acde_pkg::ADDR_CFG, 32'h3);
    slow <= 1'b1;
    start(8'hE7, 8'h05, 2'h1, 1'b0, 1'b0, 8'h00);
    wait_done();
    start(8'h92, 8'h00, 2'h0, 1'b0, 1'b0, 8'h00);
    wait_done();
    start(8'h92, 8'h34, 2'h1, 1'b0, 1'b0, 8'h00);
    wait_done();
    apb(1'b0, acde_pkg::ADDR_PARAM, 32'h0);
    `CHK(rd, 32'h00004334)
    fail_media <= 1'b1;
    start(8'hCA, 8'h03, 2'h1, 1'b1, 1'b0, 8'h00);
    wait_done();
    fail_media <= 1'b0;
    stage_on <= 1'b0;
    start(8'hC8, 8'h02, 2'h2, 1'b0, 1'b0, 8'h00);
    apb(1'b1, acde_pkg::ADDR_CMD, 32'h50);
    repeat (20) @(posedge pclk);
    stage_on <= 1'b1;
    wait_done();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
  // ****************************************
  // result check
  // ****************************************
  task automatic take(input logic [31:0] k);
    logic [63:0] e;
    // an unexpected result meets an impossible note and is reported
    e = exp_q.size() > 0 ? exp_q.pop_front() : 64'hFFFFFFFF_00000000;
    `CHK(k & e[63:32], e[31:0])
  endtask : take
  always @(posedge pclk)
  begin
    if (fis_o.data_req === 1'b1)
    begin
      take({8'h01, 4'h0, fis_o.data_dw, 8'h00});
      `CHK(stg_d, 1'b1)
    end
    if (media_o.req === 1'b1)
    begin
      take({8'h02, media_o.opcode, media_o.features, 8'h00});
      mpend = 1'b1;
    end
    if (fis_o.reg_req === 1'b1)
    begin
      take({8'h03, fis_o.irq_bit, fis_o.status[acde_pkg::ST_ERR],
        fis_o.error[acde_pkg::ER_ABRT], 5'h00, fis_o.count, 8'h00});
      `CHK(mpend, 1'b0)
    end
    if (media_done === 1'b1 || media_err === 1'b1)
      mpend = 1'b0;
    stg_d = stage_on;
  end
endmodule : tb_ata_command_dma_in_engine
